// *** hw/pfc_pkg.sv ***
// package: register map, field positions and types for the port 1 flow control register
package pfc_pkg;

  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned WORD_LSB   = 2;

  // register map
  localparam logic [11:0] P1FC_OFFSET = 12'h1A0;

  // field positions
  localparam int unsigned BIT_SELECT     = 0;
  localparam int unsigned BIT_TX_ENABLE  = 1;
  localparam int unsigned BIT_RX_ENABLE  = 2;
  localparam int unsigned BIT_TX_ACTIVE  = 3;
  localparam int unsigned BIT_RX_ACTIVE  = 4;
  localparam int unsigned BIT_DUPLEX     = 5;
  localparam int unsigned BIT_BACKPRESS  = 6;
  localparam int unsigned FIELD_W        = 7;
  localparam int unsigned RESERVED_W     = 25;

  // fixed reset values
  localparam logic        EXT_SELECT_RST = 1'b1;
  localparam logic        BIT_RST        = 1'b0;
  localparam logic [31:0] DATA_RST       = 32'h0000_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // pipeline depth of the pin synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // configuration straps and operating mode, sampled from pins
  typedef struct packed {
    logic ext_mac_mode;
    logic duplex_half;
    logic backpressure;
    logic full_duplex_pause;
    logic manual_select;
  } pfc_strap_t;

  // live port status from the port's PHY and negotiation
  typedef struct packed {
    logic half_duplex;
    logic autoneg_enable;
    logic an_pause_receive;
    logic an_pause_transmit;
  } pfc_link_t;

  // effective pause result
  typedef struct packed {
    logic receive;
    logic transmit;
  } pfc_pause_t;

endpackage

// *** hw/pfc_sync.sv ***
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module pfc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge aclk) begin
    meta_q   <= async_in;
    sync_out <= meta_q;
  end

endmodule

// *** hw/pfc_resolve.sv ***
// pause resolution between manual enables and negotiated result
`timescale 1ns/1ps
module pfc_resolve (
  input  wire logic              select_manual,
  input  wire logic              rx_enable,
  input  wire logic              tx_enable,
  input  wire pfc_pkg::pfc_link_t link,
  output pfc_pkg::pfc_pause_t     pause
);

  logic manual_path;
  logic full_duplex;

  always_comb begin
    manual_path = select_manual | ~link.autoneg_enable;
    full_duplex = ~link.half_duplex;
    if (!full_duplex) begin
      pause.receive  = 1'b0;
      pause.transmit = 1'b0;
    end else if (manual_path) begin
      pause.receive  = rx_enable;
      pause.transmit = tx_enable;
    end else begin
      pause.receive  = link.an_pause_receive;
      pause.transmit = link.an_pause_transmit;
    end
  end

endmodule

// *** hw/pfc_port1_fc.sv ***
// port 1 flow control register with axi4-lite slave and pause resolution
// Overview of operation
// - bit 6 read-write, enables half-duplex backpressure on port 1 when set.
// - bit 5 read-only, shows active duplex: 0 full, 1 half.
// - bit 4 read-only, shows whether pause receive is currently active.
// - bit 3 read-only, shows whether pause transmit is currently active.
// - bit 2 enables pause frame reception when manual selected or negotiation off.
// - bit 1 enables pause frame generation when manual selected or negotiation off.
// - select 0 with negotiation on uses negotiated pause while in full duplex; manual enables ignored.
// - select 1 makes manual enables govern pause while in full duplex.
// - external mac modes force select bit to 1 and make it read-only.
// - status bits reset from a combination of straps.
// - backpressure and pause enables reset from their own straps.
// - external mac modes reset select to 1, loader cannot overwrite it.
// - writes leave the phy advertisement register untouched.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pfc_port1_fc (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [pfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [pfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire pfc_pkg::pfc_strap_t       strap_pins,
  input  wire pfc_pkg::pfc_link_t        link_pins,
  input  wire logic                      loader_valid,
  input  wire logic [31:0]               loader_data,
  output logic                           port1_backpressure_enable,
  output logic                           port1_active_duplex,
  output logic                           port1_active_pause_receive,
  output logic                           port1_active_pause_transmit,
  output logic                           port1_manual_pause_select
);

  pfc_pkg::pfc_strap_t strap_s;
  pfc_pkg::pfc_link_t  link_s;
  pfc_pkg::pfc_pause_t pause_res;

  logic                       bp_q;
  logic                       dup_q;
  logic                       rx_act_q;
  logic                       tx_act_q;
  logic                       rx_en_q;
  logic                       tx_en_q;
  logic                       sel_q;
  logic                       aw_held_q;
  logic                       w_held_q;
  logic [pfc_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       bvalid_q;
  logic [1:0]                 bresp_q;
  logic                       rvalid_q;
  logic [1:0]                 rresp_q;
  logic [31:0]                rdata_q;
  logic                       wr_commit;
  logic                       wr_hit;
  logic                       sw_lane0;
  logic                       rd_fire;
  logic                       rd_hit;
  logic                       ext_mode;
  logic [31:0]                reg_value;

  // pin synchronisers
  pfc_sync #(
    .W ($bits(pfc_pkg::pfc_strap_t))
  ) u_strap_sync (
    .aclk     (aclk),
    .async_in (strap_pins),
    .sync_out (strap_s)
  );

  pfc_sync #(
    .W ($bits(pfc_pkg::pfc_link_t))
  ) u_link_sync (
    .aclk     (aclk),
    .async_in (link_pins),
    .sync_out (link_s)
  );

  pfc_resolve u_resolve (
    .select_manual (sel_q),
    .rx_enable     (rx_en_q),
    .tx_enable     (tx_en_q),
    .link          (link_s),
    .pause         (pause_res)
  );

  assign ext_mode = strap_s.ext_mac_mode;

  // bus decode
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign wr_commit     = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_hit        = awaddr_q[pfc_pkg::ADDR_W-1:pfc_pkg::WORD_LSB]
                         == pfc_pkg::P1FC_OFFSET[pfc_pkg::ADDR_W-1:pfc_pkg::WORD_LSB];
  assign sw_lane0      = wr_commit & wr_hit & wstrb_q[0];
  assign rd_fire       = s_axi_arvalid & s_axi_arready;
  assign rd_hit        = s_axi_araddr[pfc_pkg::ADDR_W-1:pfc_pkg::WORD_LSB]
                         == pfc_pkg::P1FC_OFFSET[pfc_pkg::ADDR_W-1:pfc_pkg::WORD_LSB];

  // read view, upper bits zero
  assign reg_value = {{pfc_pkg::RESERVED_W{1'b0}},
                      bp_q, dup_q, rx_act_q, tx_act_q, rx_en_q, tx_en_q, sel_q};

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= pfc_pkg::DATA_RST;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pfc_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? pfc_pkg::RESP_OKAY : pfc_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= pfc_pkg::RESP_OKAY;
      rdata_q  <= pfc_pkg::DATA_RST;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? pfc_pkg::RESP_OKAY : pfc_pkg::RESP_DECERR;
      rdata_q  <= rd_hit ? reg_value : pfc_pkg::DATA_RST;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // software enables, loader wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_q    <= strap_s.backpressure;
      rx_en_q <= strap_s.full_duplex_pause;
      tx_en_q <= strap_s.full_duplex_pause;
    end else if (loader_valid) begin
      bp_q    <= loader_data[pfc_pkg::BIT_BACKPRESS];
      rx_en_q <= loader_data[pfc_pkg::BIT_RX_ENABLE];
      tx_en_q <= loader_data[pfc_pkg::BIT_TX_ENABLE];
    end else if (sw_lane0) begin
      bp_q    <= wdata_q[pfc_pkg::BIT_BACKPRESS];
      rx_en_q <= wdata_q[pfc_pkg::BIT_RX_ENABLE];
      tx_en_q <= wdata_q[pfc_pkg::BIT_TX_ENABLE];
    end
  end

  // manual select, forced in external mac modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= ext_mode ? pfc_pkg::EXT_SELECT_RST : strap_s.manual_select;
    end else if (ext_mode) begin
      sel_q <= pfc_pkg::EXT_SELECT_RST;
    end else if (loader_valid) begin
      sel_q <= loader_data[pfc_pkg::BIT_SELECT];
    end else if (sw_lane0) begin
      sel_q <= wdata_q[pfc_pkg::BIT_SELECT];
    end
  end

  // live status, reset from strap combination
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dup_q    <= strap_s.duplex_half;
      rx_act_q <= ~strap_s.duplex_half & strap_s.full_duplex_pause;
      tx_act_q <= ~strap_s.duplex_half & strap_s.full_duplex_pause;
    end else begin
      dup_q    <= link_s.half_duplex;
      rx_act_q <= pause_res.receive;
      tx_act_q <= pause_res.transmit;
    end
  end

  // outputs; no path reaches the phy advertisement register
  assign port1_backpressure_enable   = bp_q;
  assign port1_active_duplex         = dup_q;
  assign port1_active_pause_receive  = rx_act_q;
  assign port1_active_pause_transmit = tx_act_q;
  assign port1_manual_pause_select   = sel_q;
  assign s_axi_bvalid                = bvalid_q;
  assign s_axi_bresp                 = bresp_q;
  assign s_axi_rvalid                = rvalid_q;
  assign s_axi_rresp                 = rresp_q;
  assign s_axi_rdata                 = rdata_q;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_sw_write;
    sw_lane0 && !loader_valid;
  endsequence

  sequence s_read_hit;
    rd_fire && rd_hit;
  endsequence

  sequence s_manual_full;
    (sel_q || !link_s.autoneg_enable) && !link_s.half_duplex;
  endsequence

  AST_BP_WRITE: assert property (
    s_sw_write |=> bp_q == $past(wdata_q[pfc_pkg::BIT_BACKPRESS]))
    else $error("backpressure enable did not take the written value");

  AST_DUPLEX_READ: assert property (
    s_read_hit |=> s_axi_rvalid && s_axi_rdata[pfc_pkg::BIT_DUPLEX] == $past(dup_q))
    else $error("duplex bit read back wrong");

  AST_RX_MANUAL: assert property (
    s_manual_full |=> port1_active_pause_receive == $past(rx_en_q))
    else $error("manual receive pause not applied");

  AST_TX_MANUAL: assert property (
    s_manual_full |=> port1_active_pause_transmit == $past(tx_en_q))
    else $error("manual transmit pause not applied");

  AST_RX_EN_WRITE: assert property (
    s_sw_write ##1 (!sel_q && link_s.autoneg_enable && !link_s.half_duplex)
      |=> rx_act_q == $past(link_s.an_pause_receive))
    else $error("receive enable not ignored under negotiation");

  AST_TX_EN_WRITE: assert property (
    s_sw_write |=> tx_en_q == $past(wdata_q[pfc_pkg::BIT_TX_ENABLE]))
    else $error("transmit enable did not take the written value");

  AST_NEGOTIATED: assert property (
    !sel_q && link_s.autoneg_enable && !link_s.half_duplex
      |=> tx_act_q == $past(link_s.an_pause_transmit))
    else $error("negotiated transmit pause not applied");

  AST_HALF_NO_PAUSE: assert property (
    link_s.half_duplex |=> !rx_act_q && !tx_act_q && dup_q)
    else $error("pause active in half duplex");

  AST_EXT_SELECT: assert property (
    ext_mode [*2] |-> sel_q && port1_manual_pause_select)
    else $error("select bit not held high in external mac mode");

  AST_STRAP_RESET: assert property (
    !$past(aresetn) |-> bp_q == $past(strap_s.backpressure)
      && rx_en_q == $past(strap_s.full_duplex_pause))
    else $error("enables did not load their straps at reset");

  AST_LOADER_SELECT: assert property (
    loader_valid && ext_mode |=> sel_q)
    else $error("loader overwrote select in external mac mode");

  AST_RESERVED_ZERO: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:pfc_pkg::FIELD_W] == '0)
    else $error("reserved bits read nonzero");

  sequence s_negotiated_full;
    !sel_q && link_s.autoneg_enable && !link_s.half_duplex;
  endsequence

  AST_BP_READ: assert property (
    s_read_hit |=> s_axi_rdata[pfc_pkg::BIT_BACKPRESS] == $past(bp_q))
    else $error("backpressure bit read back wrong");

  AST_DUPLEX_FOLLOW: assert property (
    !link_s.half_duplex |=> !port1_active_duplex)
    else $error("full duplex not reported");

  AST_ACTIVE_READ: assert property (
    s_read_hit |=> s_axi_rdata[pfc_pkg::BIT_RX_ACTIVE] == $past(rx_act_q)
      && s_axi_rdata[pfc_pkg::BIT_TX_ACTIVE] == $past(tx_act_q))
    else $error("active pause bits read back wrong");

  AST_RX_EN_TAKE: assert property (
    s_sw_write |=> rx_en_q == $past(wdata_q[pfc_pkg::BIT_RX_ENABLE]))
    else $error("receive enable did not take the written value");

  AST_TX_EN_IGNORED: assert property (
    s_sw_write ##1 s_negotiated_full |=> tx_act_q == $past(link_s.an_pause_transmit))
    else $error("transmit enable not ignored under negotiation");

  AST_RX_NEGOTIATED: assert property (
    s_negotiated_full |=> rx_act_q == $past(link_s.an_pause_receive))
    else $error("negotiated receive pause not applied");

  AST_MANUAL_SELECT: assert property (
    sel_q && !link_s.half_duplex
      |=> rx_act_q == $past(rx_en_q) && tx_act_q == $past(tx_en_q))
    else $error("manual select did not govern pause");

  AST_EXT_WRITE: assert property (
    sw_lane0 && ext_mode |=> sel_q)
    else $error("software cleared select in external mac mode");

  AST_STATUS_RESET: assert property (
    !$past(aresetn) |-> dup_q == $past(strap_s.duplex_half)
      && rx_act_q == ($past(strap_s.full_duplex_pause) && !$past(strap_s.duplex_half))
      && tx_act_q == ($past(strap_s.full_duplex_pause) && !$past(strap_s.duplex_half)))
    else $error("status bits did not load their strap combination");

  AST_SELECT_RESET: assert property (
    !$past(aresetn) && !$past(ext_mode) |-> sel_q == $past(strap_s.manual_select))
    else $error("select did not load its strap at reset");

endmodule

// *** sim/tb_port1_flow_control_select.sv ***
// testbench: port 1 flow control register over axi4-lite
`timescale 1ns/1ps
module tb_port1_flow_control_select;
  logic                     aclk;
  logic                     aresetn;
  logic [11:0]              awaddr, araddr;
  logic                     awvalid, wvalid, bready, arvalid, rready;
  logic                     awready, wready, bvalid, arready, rvalid;
  logic [31:0]              wdata, rdata, ldata;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp;
  logic                     lvalid;
  pfc_pkg::pfc_strap_t      straps;
  pfc_pkg::pfc_link_t       link;
  logic                     bp, dup, rxa, txa, sel;
  int                       n_errors;
  int                       compares;

  pfc_port1_fc pfc_port1_fc_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .strap_pins(straps), .link_pins(link), .loader_valid(lvalid), .loader_data(ldata),
    .port1_backpressure_enable(bp), .port1_active_duplex(dup),
    .port1_active_pause_receive(rxa), .port1_active_pause_transmit(txa),
    .port1_manual_pause_select(sel)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ready sampled at the falling edge, so the rising edge sees the same value
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
                           output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= be;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid & arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] d);
    logic [1:0] r;
    axi_write(pfc_pkg::P1FC_OFFSET, d, 4'hF, r);
    check("write resp", {30'h0, r}, {30'h0, pfc_pkg::RESP_OKAY});
  endtask

  task automatic expect_reg(input string what, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(pfc_pkg::P1FC_OFFSET, d, r);
    check(what, d, exp);
    check("read resp", {30'h0, r}, {30'h0, pfc_pkg::RESP_OKAY});
    @(negedge aclk);
    check("status pins", {27'h0, bp, dup, rxa, txa, sel},
          {27'h0, exp[6], exp[5], exp[4], exp[3], exp[0]});
  endtask

  // pin changes take two edges through the synchroniser, three to the status bits
  task automatic set_link(input logic [3:0] v);
    @(posedge aclk);
    link <= pfc_pkg::pfc_link_t'(v);
    repeat (4) @(posedge aclk);
  endtask

  task automatic do_reset(input logic [4:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    straps <= pfc_pkg::pfc_strap_t'(s);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check("reset pins", {27'h0, bp, dup, rxa, txa, sel},
          {27'h0, s[2], s[3], !s[3] & s[1], !s[3] & s[1], s[4] | s[0]});
    @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic loader(input logic [31:0] d);
    @(posedge aclk);
    lvalid <= 1'b1;
    ldata <= d;
    @(posedge aclk);
    lvalid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic s_reset_values();
    do_reset(5'h06);
    repeat (4) @(posedge aclk);
    expect_reg("reset word", 32'h0000_005E);
  endtask

  task automatic s_reserved_bp();
    wr(32'hFFFF_FF86);
    expect_reg("reserved cleared", 32'h0000_001E);
    wr(32'h0000_0040);
    expect_reg("backpressure on", 32'h0000_0058);
  endtask

  task automatic s_negotiated();
    set_link(4'h6);
    expect_reg("negotiated rx", 32'h0000_0050);
    set_link(4'h2);
    expect_reg("autoneg off", 32'h0000_0040);
    wr(32'h0000_0044);
    expect_reg("rx enable", 32'h0000_0054);
    wr(32'h0000_0042);
    expect_reg("tx enable", 32'h0000_004A);
  endtask

  task automatic s_manual();
    set_link(4'h4);
    wr(32'h0000_0045);
    expect_reg("manual rx", 32'h0000_0055);
    set_link(4'hC);
    expect_reg("half duplex", 32'h0000_0065);
    set_link(4'h4);
  endtask

  task automatic s_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(12'h1A4, 32'h0000_0000, 4'hF, r);
    check("unmapped bresp", {30'h0, r}, {30'h0, pfc_pkg::RESP_DECERR});
    axi_read(12'h1A4, d, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, pfc_pkg::RESP_DECERR});
    check("unmapped rdata", d, 32'h0000_0000);
    axi_write(pfc_pkg::P1FC_OFFSET, 32'h0000_0000, 4'hE, r);
    check("lane0 off bresp", {30'h0, r}, {30'h0, pfc_pkg::RESP_OKAY});
    expect_reg("unchanged", 32'h0000_0055);
  endtask

  task automatic s_loader();
    loader(32'h0000_0003);
    expect_reg("loader word", 32'h0000_000B);
  endtask

  task automatic s_ext_mode();
    do_reset(5'h10);
    set_link(4'h7);
    expect_reg("ext reset", 32'h0000_0001);
    wr(32'h0000_0000);
    expect_reg("ext select held", 32'h0000_0001);
    loader(32'h0000_0000);
    expect_reg("ext loader", 32'h0000_0001);
    wr(32'h0000_0006);
    expect_reg("ext host pause", 32'h0000_001F);
  endtask

  initial begin
    n_errors = 0;
    compares = 0;
    aresetn = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    lvalid = 1'b0;
    ldata = 32'h0000_0000;
    straps = pfc_pkg::pfc_strap_t'(5'h06);
    link = pfc_pkg::pfc_link_t'(4'h7);
    s_reset_values();
    s_reserved_bp();
    s_negotiated();
    s_manual();
    s_unmapped();
    s_loader();
    s_ext_mode();
    conclude();
  end

  initial begin
    #(25ns * 5000);
    n_errors++;
    conclude();
  end
endmodule
